// ===== lcd_seg_pkg.sv
package lcd_seg_pkg;

  // Register offsets, byte addresses of aligned words
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PTR_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] VADJ_OFS = 8'h10;

  // Control word, bit 0 at osc_en
  typedef struct packed {
    logic shared_supply;
    logic supply_det_en;
    logic vadj_en;
    logic [1:0] blink;
    logic frame_hi;
    logic duty8;
    logic disp_en;
    logic bias_en;
    logic osc_en;
  } ctrl_s;

  localparam int CTRL_W = 10;
  localparam ctrl_s CTRL_RESET = ctrl_s'(10'h080);

  // Display memory shape
  localparam int RAM_DEPTH = 16;
  localparam int RAM_W = 8;
  localparam int PTR_W = 4;
  localparam int VADJ_W = 4;
  localparam logic [3:0] PTR_MAX4 = 4'h9;
  localparam logic [3:0] PTR_MAX8 = 4'hF;
  localparam logic [3:0] PTR_ZERO = 4'h0;

  // Pins
  localparam int N_ELEC = 20;
  localparam int N_BP = 4;
  localparam int N_DUAL = 4;
  localparam logic [2:0] SLOT_LAST4 = 3'h3;
  localparam logic [2:0] SLOT_LAST8 = 3'h7;

  // Drive levels in bias steps above ground
  typedef logic [2:0] level_t;
  localparam level_t LVL_GND = 3'h0;
  localparam level_t LVL_ONE = 3'h1;
  localparam level_t LVL_TWO = 3'h2;
  localparam level_t LVL_TOP3 = 3'h3;
  localparam level_t LVL_TOP4 = 3'h4;
  localparam level_t LVL_RESET = LVL_TOP3;

  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SYS_HZ = 32768;
  localparam int SYS_DIV = CLK_HZ / SYS_HZ;
  localparam logic [10:0] SYS_DIV_M1 = 11'(SYS_DIV - 1);
  localparam int FRAME_LO_HZ = 80;
  localparam int FRAME_HI_HZ = 160;
  localparam int DUTY4 = 4;
  localparam int DUTY8 = 8;
  localparam logic [5:0] SLOT_LO4 = 6'(SYS_HZ / (FRAME_LO_HZ * 2 * DUTY4) - 1);
  localparam logic [5:0] SLOT_HI4 = 6'(SYS_HZ / (FRAME_HI_HZ * 2 * DUTY4) - 1);
  localparam logic [5:0] SLOT_LO8 = 6'(SYS_HZ / (FRAME_LO_HZ * 2 * DUTY8) - 1);
  localparam logic [5:0] SLOT_HI8 = 6'(SYS_HZ / (FRAME_HI_HZ * 2 * DUTY8) - 1);

  // Blink dividers and the counter bit that marks the dark half
  localparam int BLINK_DIV1 = 16384;
  localparam int BLINK_DIV2 = 32768;
  localparam int BLINK_DIV3 = 65536;
  localparam int BLINK_BIT1 = $clog2(BLINK_DIV1) - 1;
  localparam int BLINK_BIT2 = $clog2(BLINK_DIV2) - 1;
  localparam int BLINK_BIT3 = $clog2(BLINK_DIV3) - 1;
  localparam logic [1:0] BLINK_OFF = 2'h0;
  localparam logic [1:0] BLINK_M1 = 2'h1;
  localparam logic [1:0] BLINK_M2 = 2'h2;

endpackage : lcd_seg_pkg

// ===== lcd_segment_display_core.sv
// Contract
// - Reset drives all outputs at supply level.
// - Reset selects quarter duty, third bias.
// - Reset: oscillator, bias, display all off.
// - Reset: adjust on, supply detect off.
// - Reset: shared pin acts as electrode.
// - Reset frame rate is 80 Hz.
// - Reset leaves blinking off.
// - Image held in 16x8 RAM.
// - RAM one lights segment, zero darkens.
// - Each bit drives in its backplane slot.
// - Quarter duty: two electrodes per location.
// - Eighth duty: one electrode per location.
// - Data bytes are least significant bit first.
// - Internal clock sets all drive timing.
// - Third bias bypasses the centre resistor.
// - Two drive configurations, paired duty and bias.
// - Twenty or sixteen electrode outputs driven.
// - Four or eight backplane outputs driven.
// - Pointer set, then single or run writes.
// - Two-bit blink mode, three divided rates.
// - Frame rate selects 80 or 160 Hz.
// - Pointer advances, wraps at mode maximum.
`timescale 1ns/1ns
module lcd_segment_display_core #(
  parameter int SHARED_IDX = 19
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output lcd_seg_pkg::level_t [lcd_seg_pkg::N_BP-1:0] backplane_output,
  output lcd_seg_pkg::level_t [lcd_seg_pkg::N_ELEC-1:0] electrode_output,
  output logic osc_running,
  output logic bias_gen_on,
  output logic center_bypass,
  output logic vadj_enable,
  output logic [lcd_seg_pkg::VADJ_W-1:0] vadj_code,
  output logic supply_detect_en,
  output logic shared_is_electrode
);

  lcd_seg_pkg::ctrl_s ctrl_reg;
  logic [lcd_seg_pkg::VADJ_W-1:0] vadj_reg;
  logic [lcd_seg_pkg::PTR_W-1:0] ptr_reg;
  logic [lcd_seg_pkg::RAM_DEPTH-1:0][lcd_seg_pkg::RAM_W-1:0] ram_reg;
  logic [31:0] prdata_reg;
  logic [10:0] div_reg;
  logic [5:0] slot_cnt_reg;
  logic [2:0] slot_idx_reg;
  logic pol_reg;
  logic [15:0] blink_cnt_reg;
  lcd_seg_pkg::level_t [lcd_seg_pkg::N_BP-1:0] bp_reg;
  lcd_seg_pkg::level_t [lcd_seg_pkg::N_ELEC-1:0] elec_reg;

  logic access;
  logic setup;
  logic hit_ctrl;
  logic hit_ptr;
  logic hit_data;
  logic hit_stat;
  logic hit_vadj;
  logic hit_any;
  logic data_wr;
  logic data_rd;
  logic [lcd_seg_pkg::PTR_W-1:0] ptr_max;
  logic [lcd_seg_pkg::PTR_W-1:0] ptr_next;
  logic [31:0] rd_mux;
  logic tick;
  logic [5:0] slot_len_m1;
  logic [2:0] slot_last;
  logic blank;
  logic drive_on;
  logic bias4;
  lcd_seg_pkg::level_t top_lvl;

  // Backplane level: selected swings full scale, others sit one step in
  function automatic lcd_seg_pkg::level_t bp_lvl(input logic sel, input logic pol, input logic b4);
    lcd_seg_pkg::level_t top;
    top = b4 ? lcd_seg_pkg::LVL_TOP4 : lcd_seg_pkg::LVL_TOP3;
    if (sel)
      bp_lvl = pol ? lcd_seg_pkg::LVL_GND : top;
    else
      bp_lvl = pol ? 3'(top - lcd_seg_pkg::LVL_ONE) : lcd_seg_pkg::LVL_ONE;
  endfunction : bp_lvl

  // Electrode level: lit sits opposite the selected backplane
  function automatic lcd_seg_pkg::level_t elec_lvl(input logic on, input logic pol, input logic b4);
    lcd_seg_pkg::level_t top;
    top = b4 ? lcd_seg_pkg::LVL_TOP4 : lcd_seg_pkg::LVL_TOP3;
    if (on)
      elec_lvl = pol ? top : lcd_seg_pkg::LVL_GND;
    else
      elec_lvl = pol ? 3'(top - lcd_seg_pkg::LVL_TWO) : lcd_seg_pkg::LVL_TWO;
  endfunction : elec_lvl

  // Bus decode; zero wait states, so pready only qualifies the access
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit_ctrl = (paddr == lcd_seg_pkg::CTRL_OFS);
  assign hit_ptr = (paddr == lcd_seg_pkg::PTR_OFS);
  assign hit_data = (paddr == lcd_seg_pkg::DATA_OFS);
  assign hit_stat = (paddr == lcd_seg_pkg::STAT_OFS);
  assign hit_vadj = (paddr == lcd_seg_pkg::VADJ_OFS);
  assign hit_any = hit_ctrl | hit_ptr | hit_data | hit_stat | hit_vadj;
  assign pready = access;
  assign pslverr = access & ~hit_any;
  assign prdata = prdata_reg;
  assign data_wr = access & pwrite & hit_data;
  assign data_rd = access & ~pwrite & hit_data;

  // bias follows duty, no other pairing exists
  assign bias4 = ctrl_reg.duty8;
  assign top_lvl = bias4 ? lcd_seg_pkg::LVL_TOP4 : lcd_seg_pkg::LVL_TOP3;
  // centre resistor out for third bias
  assign center_bypass = ~bias4;
  assign osc_running = ctrl_reg.osc_en;
  assign bias_gen_on = ctrl_reg.bias_en;
  assign vadj_enable = ctrl_reg.vadj_en;
  assign vadj_code = vadj_reg;
  assign supply_detect_en = ctrl_reg.supply_det_en;
  assign shared_is_electrode = ~ctrl_reg.shared_supply;
  assign drive_on = ctrl_reg.osc_en & ctrl_reg.bias_en & ctrl_reg.disp_en;

  // Read mux, sampled in setup so read data leaves a flop
  always_comb
  begin
    rd_mux = '0;
    unique case (1'b1)
      hit_ctrl: rd_mux = 32'(ctrl_reg);
      hit_ptr: rd_mux = 32'(ptr_reg);
      // byte returned as stored, bit 7 highest
      hit_data: rd_mux = 32'(ram_reg[ptr_reg]);
      hit_stat: rd_mux = 32'({blank, pol_reg, slot_idx_reg, drive_on});
      hit_vadj: rd_mux = 32'(vadj_reg);
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= '0;
    else if (setup && !pwrite)
      prdata_reg <= rd_mux;
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= lcd_seg_pkg::CTRL_RESET;
    else if (access && pwrite && hit_ctrl)
      ctrl_reg <= lcd_seg_pkg::ctrl_s'(pwdata[lcd_seg_pkg::CTRL_W-1:0]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vadj_reg <= '0;
    else if (access && pwrite && hit_vadj)
      vadj_reg <= pwdata[lcd_seg_pkg::VADJ_W-1:0];
  end

  // advance and wrap at the mode's last location
  assign ptr_max = ctrl_reg.duty8 ? lcd_seg_pkg::PTR_MAX8 : lcd_seg_pkg::PTR_MAX4;
  assign ptr_next = (ptr_reg >= ptr_max) ? lcd_seg_pkg::PTR_ZERO : 4'(ptr_reg + 4'h1);

  // pointer loaded first, then any run of data accesses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr_reg <= lcd_seg_pkg::PTR_ZERO;
    else if (access && pwrite && hit_ptr)
      ptr_reg <= pwdata[lcd_seg_pkg::PTR_W-1:0];
    else if (data_wr || data_rd)
      ptr_reg <= ptr_next;
  end

  // display image in flops, cleared at reset by choice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ram_reg <= '0;
    else if (data_wr)
      ram_reg[ptr_reg] <= pwdata[lcd_seg_pkg::RAM_W-1:0];
  end

  // system tick divided from bus clock, stopped with oscillator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= '0;
    else if (!ctrl_reg.osc_en || div_reg == lcd_seg_pkg::SYS_DIV_M1)
      div_reg <= '0;
    else
      div_reg <= div_reg + 11'h1;
  end

  assign tick = ctrl_reg.osc_en && (div_reg == lcd_seg_pkg::SYS_DIV_M1);

  // slot length from frame rate and duty
  always_comb
  begin
    unique case ({ctrl_reg.duty8, ctrl_reg.frame_hi})
      2'b00: slot_len_m1 = lcd_seg_pkg::SLOT_LO4;
      2'b01: slot_len_m1 = lcd_seg_pkg::SLOT_HI4;
      2'b10: slot_len_m1 = lcd_seg_pkg::SLOT_LO8;
      2'b11: slot_len_m1 = lcd_seg_pkg::SLOT_HI8;
    endcase
  end

  // four or eight slots per half frame
  assign slot_last = ctrl_reg.duty8 ? lcd_seg_pkg::SLOT_LAST8 : lcd_seg_pkg::SLOT_LAST4;

  // slot sequencer; polarity flips each half frame to keep DC off the glass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_cnt_reg <= '0;
      slot_idx_reg <= '0;
      pol_reg <= 1'b0;
    end
    else if (!ctrl_reg.osc_en || (access && pwrite && hit_ctrl)) // Restart, so no slot outlives a duty change
    begin
      slot_cnt_reg <= '0;
      slot_idx_reg <= '0;
      pol_reg <= 1'b0;
    end
    else if (tick)
    begin
      if (slot_cnt_reg >= slot_len_m1)
      begin
        slot_cnt_reg <= '0;
        if (slot_idx_reg >= slot_last)
        begin
          slot_idx_reg <= '0;
          pol_reg <= ~pol_reg;
        end
        else
          slot_idx_reg <= slot_idx_reg + 3'h1;
      end
      else
        slot_cnt_reg <= slot_cnt_reg + 6'h1;
    end
  end

  // free-running blink counter on system ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blink_cnt_reg <= '0;
    else if (tick)
      blink_cnt_reg <= blink_cnt_reg + 16'h1;
  end

  // dark half chosen by counter bit; RAM untouched
  always_comb
  begin
    unique case (ctrl_reg.blink)
      lcd_seg_pkg::BLINK_OFF: blank = 1'b0;
      lcd_seg_pkg::BLINK_M1: blank = blink_cnt_reg[lcd_seg_pkg::BLINK_BIT1];
      lcd_seg_pkg::BLINK_M2: blank = blink_cnt_reg[lcd_seg_pkg::BLINK_BIT2];
      default: blank = blink_cnt_reg[lcd_seg_pkg::BLINK_BIT3];
    endcase
  end

  // Dedicated backplane pins
  for (genvar b = 0; b < lcd_seg_pkg::N_BP; b++)
  begin : g_bp
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        bp_reg[b] <= lcd_seg_pkg::LVL_RESET;
      else if (!drive_on)
        bp_reg[b] <= top_lvl;
      else
        bp_reg[b] <= bp_lvl(slot_idx_reg == 3'(b), pol_reg, bias4);
    end
  end

  // Electrode pins; first four double as backplanes 4-7 at eighth duty
  for (genvar e = 0; e < lcd_seg_pkg::N_ELEC; e++)
  begin : g_elec
    logic on4;
    logic on8;
    lcd_seg_pkg::level_t dual_lvl;
    lcd_seg_pkg::level_t lvl_next;

    // two electrodes share a byte, low nibble even
    assign on4 = ram_reg[e / 2][{1'(e % 2), slot_idx_reg[1:0]}];

    if (e < lcd_seg_pkg::N_DUAL)
    begin : g_dual
      assign dual_lvl = bp_lvl(slot_idx_reg == 3'(e + lcd_seg_pkg::N_BP), pol_reg, bias4);
      assign on8 = 1'b0;
    end
    else
    begin : g_elec8
      // one location per electrode, bit k to slot k
      assign on8 = ram_reg[e - lcd_seg_pkg::N_DUAL][slot_idx_reg];
      assign dual_lvl = lcd_seg_pkg::LVL_GND;
    end

    always_comb
    begin
      if (!drive_on || (ctrl_reg.shared_supply && e == SHARED_IDX))
        lvl_next = top_lvl;
      else if (ctrl_reg.duty8 && e < lcd_seg_pkg::N_DUAL)
        lvl_next = dual_lvl;
      else if (ctrl_reg.duty8)
        // lit only outside the dark half
        lvl_next = elec_lvl(on8 & ~blank, pol_reg, bias4);
      else
        lvl_next = elec_lvl(on4 & ~blank, pol_reg, bias4);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        elec_reg[e] <= lcd_seg_pkg::LVL_RESET;
      else
        elec_reg[e] <= lvl_next;
    end
  end

  assign backplane_output = bp_reg;
  assign electrode_output = elec_reg;

  // Checks beside the logic
  a_off_supply: assert property (
    @(posedge pclk) disable iff (!presetn)
    !drive_on |=> (backplane_output[0] == $past(top_lvl)) && (electrode_output[5] == $past(top_lvl)))
    else $error("Idle outputs not at supply level");

  a_ptr_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (data_wr && ptr_reg == ptr_max) |=> ptr_reg == lcd_seg_pkg::PTR_ZERO)
    else $error("Pointer did not wrap");

  a_ptr_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((data_wr || data_rd) && ptr_reg < ptr_max) |=> ptr_reg == $past(ptr_reg) + 4'h1)
    else $error("Pointer did not advance by one");

  a_ram_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    data_wr |=> ram_reg[$past(ptr_reg)] == $past(pwdata[7:0]))
    else $error("Display byte not stored");

  a_bias_pair: assert property (
    @(posedge pclk) disable iff (!presetn)
    !drive_on |=> backplane_output[1] == ($past(center_bypass) ? lcd_seg_pkg::LVL_TOP3 : lcd_seg_pkg::LVL_TOP4))
    else $error("Bias not paired with duty");

  a_blink_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    (drive_on && ctrl_reg.blink == lcd_seg_pkg::BLINK_OFF && !ctrl_reg.duty8 && !pol_reg
      && ram_reg[0][slot_idx_reg[1:0]]) |=> electrode_output[0] == lcd_seg_pkg::LVL_GND)
    else $error("Lit segment blanked while blinking is off");

  a_slot_range: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg.duty8 |-> slot_idx_reg <= lcd_seg_pkg::SLOT_LAST4)
    else $error("Slot beyond quarter duty range");

  a_tick_gap: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick [*8])
    else $error("System ticks too close");

  a_bp_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    (drive_on && slot_idx_reg == 3'h0 && !pol_reg) |=> backplane_output[0] == $past(top_lvl))
    else $error("Backplane 0 not selected in its slot");

  a_bad_addr: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && !hit_any) |-> pslverr ##1 $stable(ptr_reg))
    else $error("Unmapped access not refused");

endmodule : lcd_segment_display_core

// ===== lcd_glass_model.sv
`timescale 1ns/1ns
module lcd_glass_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic center_bypass,
  input wire lcd_seg_pkg::level_t [lcd_seg_pkg::N_BP-1:0] backplane_output,
  input wire lcd_seg_pkg::level_t [lcd_seg_pkg::N_ELEC-1:0] electrode_output,
  output logic [lcd_seg_pkg::N_ELEC-1:0] lit_seen
);

  // Full-scale swing between two pins, set by the bias mode
  function automatic logic full_swing(input lcd_seg_pkg::level_t a, input lcd_seg_pkg::level_t b,
                                      input logic third);
    lcd_seg_pkg::level_t full;
    lcd_seg_pkg::level_t diff;
    full = third ? lcd_seg_pkg::LVL_TOP3 : lcd_seg_pkg::LVL_TOP4;
    diff = (a > b) ? a - b : b - a;
    return diff == full;
  endfunction : full_swing

  // segment turns on
  // Sticky, so a short slot is not missed by a late sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lit_seen <= '0;
    else
      for (int e = 0; e < lcd_seg_pkg::N_ELEC; e++)
      begin
        for (int b = 0; b < lcd_seg_pkg::N_BP; b++)
        begin
          if (full_swing(backplane_output[b], electrode_output[e], center_bypass))
            lit_seen[e] <= 1'b1;
        end
        for (int b = 0; b < lcd_seg_pkg::N_DUAL; b++)
        begin
          if (!center_bypass && full_swing(electrode_output[b], electrode_output[e], center_bypass))
            lit_seen[e] <= 1'b1;
        end
      end
  end

endmodule : lcd_glass_model

// ===== tb_lcd_segment_display_core.sv
`timescale 1ns/1ns
module tb_lcd_segment_display_core;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err;
  lcd_seg_pkg::level_t [lcd_seg_pkg::N_BP-1:0] backplane_output;
  lcd_seg_pkg::level_t [lcd_seg_pkg::N_ELEC-1:0] electrode_output;
  logic osc_running, bias_gen_on, center_bypass, vadj_enable, supply_detect_en, shared_is_electrode;
  logic [lcd_seg_pkg::VADJ_W-1:0] vadj_code;
  logic [lcd_seg_pkg::N_ELEC-1:0] lit_seen;
  logic [31:0] exp_rd [3];
  int mismatches;
  int n_compared;

  lcd_segment_display_core lcd_segment_display_core_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .backplane_output, .electrode_output, .osc_running, .bias_gen_on, .center_bypass,
    .vadj_enable, .vadj_code, .supply_detect_en, .shared_is_electrode
  );

  lcd_glass_model lcd_glass_model_inst (
    .pclk, .presetn, .center_bypass, .backplane_output, .electrode_output, .lit_seen
  );

  // 50 MHz clock
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; read data and error taken at the ready edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        mismatches++;
        print_verdict();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (50000) @(posedge pclk);
    for (int i = 0; i < lcd_seg_pkg::N_ELEC; i++)
      check("electrode", 32'(electrode_output[i]), 32'(lcd_seg_pkg::LVL_TOP3));
    for (int i = 0; i < lcd_seg_pkg::N_BP; i++)
      check("backplane", 32'(backplane_output[i]), 32'(lcd_seg_pkg::LVL_TOP3));
    apb(1'b0, lcd_seg_pkg::CTRL_OFS, 32'h0000_0000);
    check("ctrl", rd, 32'h0000_0080);
    check("bypass", 32'(center_bypass), 32'h0000_0001);
    check("osc", 32'(osc_running), 32'h0000_0000);
    check("bias", 32'(bias_gen_on), 32'h0000_0000);
    check("vadj_en", 32'(vadj_enable), 32'h0000_0001);
    check("detect", 32'(supply_detect_en), 32'h0000_0000);
    check("shared", 32'(shared_is_electrode), 32'h0000_0001);
    // Run across the top of the quarter-duty map
    exp_rd = '{32'h0000_00A5, 32'h0000_0010, 32'h0000_0001};
    apb(1'b1, lcd_seg_pkg::PTR_OFS, 32'h0000_0008);
    for (int i = 0; i < 3; i++)
      apb(1'b1, lcd_seg_pkg::DATA_OFS, exp_rd[i]);
    apb(1'b1, lcd_seg_pkg::PTR_OFS, 32'h0000_0008);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, lcd_seg_pkg::DATA_OFS, 32'h0000_0000);
      check("ram", rd, exp_rd[i]);
    end
    apb(1'b1, 8'h14, 32'h0000_0001);
    check("slverr", 32'(err), 32'h0000_0001);
    // Every blink mode and both frame rates
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, lcd_seg_pkg::CTRL_OFS, 32'h0000_0080 | 32'(m << 5) | 32'((m & 1) << 4));
      apb(1'b0, lcd_seg_pkg::CTRL_OFS, 32'h0000_0000);
      check("ctrl_mode", rd, 32'h0000_0080 | 32'(m << 5) | 32'((m & 1) << 4));
    end
    // Supply pin function and supply detect switched on
    apb(1'b1, lcd_seg_pkg::CTRL_OFS, 32'h0000_0380);
    check("shared_off", 32'(shared_is_electrode), 32'h0000_0000);
    check("detect_on", 32'(supply_detect_en), 32'h0000_0001);
    apb(1'b1, lcd_seg_pkg::VADJ_OFS, 32'h0000_0005);
    check("vadj", 32'(vadj_code), 32'h0000_0005);
    // Quarter duty drive, first slot of the frame
    apb(1'b1, lcd_seg_pkg::CTRL_OFS, 32'h0000_0087);
    repeat (4000) @(posedge pclk);
    check("osc_on", 32'(osc_running), 32'h0000_0001);
    check("bp0", 32'(backplane_output[0]), 32'h0000_0003);
    check("bp1", 32'(backplane_output[1]), 32'h0000_0001);
    check("el0", 32'(electrode_output[0]), 32'h0000_0000);
    check("el1", 32'(electrode_output[1]), 32'h0000_0002);
    check("lit4", 32'(lit_seen), 32'h0009_0001);
    apb(1'b1, lcd_seg_pkg::CTRL_OFS, 32'h0000_0080);
    repeat (3) @(posedge pclk);
    check("off", 32'(electrode_output[0]), 32'h0000_0003);
    // Eighth duty drive, fourth bias
    apb(1'b1, lcd_seg_pkg::CTRL_OFS, 32'h0000_008F);
    repeat (4000) @(posedge pclk);
    check("bypass8", 32'(center_bypass), 32'h0000_0000);
    check("bp0_8", 32'(backplane_output[0]), 32'h0000_0004);
    check("bp4_8", 32'(electrode_output[0]), 32'h0000_0001);
    check("el4_8", 32'(electrode_output[4]), 32'h0000_0000);
    check("lit8", 32'(lit_seen), 32'h0009_1011);
    apb(1'b1, lcd_seg_pkg::PTR_OFS, 32'h0000_000F);
    apb(1'b1, lcd_seg_pkg::DATA_OFS, 32'h0000_0000);
    apb(1'b0, lcd_seg_pkg::DATA_OFS, 32'h0000_0000);
    check("wrap8", rd, 32'h0000_0001);
    print_verdict();
  end

endmodule : tb_lcd_segment_display_core
